// File: src/hotswap_gate_sequencer.sv
`timescale 1ns/1ps
module hotswap_gate_sequencer
   import hotswap_pkg::*;
(
   input  wire logic                   pclk,            // apb clock, 100 MHz
   input  wire logic                   presetn,         // async reset, active low
   input  wire logic                   psel,            // apb select
   input  wire logic                   penable,         // apb access phase
   input  wire logic                   pwrite,          // apb direction
   input  wire logic [7:0]             paddr,           // apb byte address
   input  wire logic [31:0]            pwdata,          // apb write data
   output logic      [31:0]            prdata,          // apb read data
   output logic                        pready,          // apb ready
   output logic                        pslverr,         // apb error
   input  wire hotswap_pkg::sense_t    sense,           // raw comparator results
   input  wire logic                   retry_latch_sel, // retry-select input: high latches
   input  wire logic [4:0]             warn_cross,      // warning crossings vin,vout,i,p,t
   output hotswap_pkg::gate_ctl_t      gate_ctl,        // gate drive selects
   output hotswap_pkg::timer_ctl_t     timer_ctl,       // timer node selects
   output logic                        power_good_out,  // power good
   output logic                        smb_alert_n      // smbus alert, active low
);
   import hotswap_pkg::*;

   sense_t      sense_meta;
   sense_t      s;
   logic        retry_meta;
   logic        retry_sync;
   seq_state_t  state;
   seq_state_t  next_state;
   logic [2:0]  retry_sel;
   logic [4:0]  warn_mask;
   logic [4:0]  warn_flags;
   logic        defaults_flag;
   logic        fault_flag;
   logic        breaker_flag;
   logic [3:0]  cycle_cnt;
   logic [4:0]  retries_done;
   logic        retry_allowed;
   logic        apb_wr;
   logic        apb_rd;
   logic        clear_cmd;
   logic        limiting;
   logic        supply_bad;
   gate_ctl_t   next_gate;
   timer_ctl_t  next_timer;

   // two-flop synchroniser for the comparators; first stage is read by the second only
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sense_meta <= '0;
         s          <= '0;
      end else begin
         sense_meta <= sense;
         s          <= sense_meta;
      end
   end

   // retry-select pin gets the same two stages; a bounce only delays the decision
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         retry_meta <= 1'b0;
         retry_sync <= 1'b0;
      end else begin
         retry_meta <= retry_latch_sel;
         retry_sync <= retry_meta;
      end
   end

   assign apb_wr    = psel && penable && pwrite;
   assign apb_rd    = psel && !penable && !pwrite;
   assign clear_cmd = apb_wr && (paddr == ctrl_addr) && pwdata[ctrl_clear_bit];
   assign limiting  = s.cur_lim || s.pwr_lim;
   assign supply_bad = !s.uv_ok || s.ov_hi;

   // retry budget; register value 7 follows the retry-select input
   always_comb begin
      case (retry_sel)
         retry_zero:     retry_allowed = 1'b0;
         retry_one:      retry_allowed = retries_done < 5'h01;
         retry_two:      retry_allowed = retries_done < 5'h02;
         retry_four:     retry_allowed = retries_done < 5'h04;
         retry_eight:    retry_allowed = retries_done < 5'h08;
         retry_sixteen:  retry_allowed = retries_done < 5'h10;
         retry_infinite: retry_allowed = 1'b1;
         default:        retry_allowed = !retry_sync;
      endcase
   end

   // apb control registers; single-cycle access, no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         retry_sel <= retry_reset;
         warn_mask <= wmask_reset;
      end else if (apb_wr && paddr == ctrl_addr) begin
         retry_sel <= pwdata[ctrl_retry_lsb +: 3];
         warn_mask <= pwdata[ctrl_wmask_lsb +: 5];
      end
   end

   // apb handshake; pready answers every setup cycle, so there are no wait states
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready  <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready  <= psel && !penable;
         pslverr <= psel && !penable && (paddr != ctrl_addr) &&
                    (paddr != status_addr) && (paddr != warn_addr);
      end
   end

   // apb read data, registered in the setup cycle so it stands in access
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= '0;
      end else if (apb_rd) begin
         case (paddr)
            ctrl_addr:   prdata <= {19'h0, warn_mask, 1'b0, retry_sel, 4'h0};
            status_addr: prdata <= {16'h0, retries_done, cycle_cnt, breaker_flag,
                                    fault_flag, defaults_flag, state};
            warn_addr:   prdata <= {27'h0, warn_flags};
            default:     prdata <= '0;
         endcase
      end
   end

   // defaults-loaded flag; only a reset sets it, only clear-faults drops it
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         defaults_flag <= 1'b1;
      end else if (clear_cmd) begin
         defaults_flag <= 1'b0;
      end
   end

   // fault flag; a fresh timeout wins over a clear in the same cycle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         fault_flag <= 1'b0;
      end else if (state == st_inrush && s.timer_hi && limiting) begin
         fault_flag <= 1'b1;
      end else if (clear_cmd) begin
         fault_flag <= 1'b0;
      end
   end

   // breaker flag; a trip in the clearing cycle survives the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         breaker_flag <= 1'b0;
      end else if (s.breaker) begin
         breaker_flag <= 1'b1;
      end else if (clear_cmd) begin
         breaker_flag <= 1'b0;
      end
   end

   // sticky warning crossings; a new crossing is or-ed in after the clear
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         warn_flags <= '0;
      end else begin
         warn_flags <= (clear_cmd ? 5'h00 : warn_flags) | warn_cross;
      end
   end

   // alert low for defaults, faults or unmasked warnings
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         smb_alert_n <= 1'b1;
      end else begin
         smb_alert_n <= !(s.por_ok && (defaults_flag || fault_flag || breaker_flag ||
                          |(warn_flags & warn_mask)));
      end
   end

   // sequencing state register
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= st_por;
      end else begin
         state <= next_state;
      end
   end

   // restart cycle counter; cleared at every fault so each sequence starts fresh
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cycle_cnt <= '0;
      end else if (state == st_fault) begin
         cycle_cnt <= '0;
      end else if (state == st_rst_down && s.timer_mid) begin
         cycle_cnt <= cycle_cnt + 4'h1;
      end
   end

   // retry counter; it saturates instead of wrapping into a fresh budget
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         retries_done <= '0;
      end else if (state == st_por || state == st_normal || clear_cmd) begin
         retries_done <= '0;
      end else if (state == st_rst_last && s.timer_lo && retries_done != 5'h1F) begin
         retries_done <= retries_done + 5'h01;
      end
   end

   // next state
   always_comb begin
      next_state = state;
      case (state)
         st_por:      if (s.por_ok) next_state = st_insert;
         st_insert:   if (s.timer_hi) next_state = st_ins_dis;
         st_ins_dis:  if (s.timer_lo) next_state = st_wait_uv;
         st_wait_uv:  if (!supply_bad) next_state = st_inrush;
         st_inrush: begin
            if (s.timer_hi && limiting) next_state = st_fault;
            else if (!limiting && s.fb_hi) next_state = st_normal;
         end
         st_normal:   if (limiting) next_state = st_inrush;
         st_fault: begin
            if (retry_allowed) next_state = st_rst_down;
            else next_state = st_latched;
         end
         st_latched:  if (supply_bad && s.timer_lo) next_state = st_wait_uv;
         st_rst_up:   if (s.timer_hi) next_state = st_rst_down;
         st_rst_down: begin
            if (s.timer_mid) begin
               // seven full cycles, then the eighth falling ramp releases the gate
               if (cycle_cnt >= restart_cycles) next_state = st_rst_last;
               else next_state = st_rst_up;
            end
         end
         st_rst_last: if (s.timer_lo) next_state = st_inrush;
         default:     next_state = st_por;
      endcase
      if (!s.por_ok) begin
         next_state = st_por;
      end else if (supply_bad && (state == st_inrush || state == st_normal)) begin
         next_state = st_wait_uv;
      end
   end

   // gate and timer drive decoded from state
   always_comb begin
      next_gate  = '0;
      next_timer = '0;
      case (state)
         st_por: begin
            next_gate.strong_pd = 1'b1;
            next_timer.ground   = 1'b1;
         end
         st_insert: begin
            next_gate.weak_pd     = 1'b1;
            next_timer.ins_charge = 1'b1;
         end
         st_ins_dis: begin
            next_gate.weak_pd   = 1'b1;
            next_timer.fast_dis = 1'b1;
         end
         st_wait_uv: begin
            next_gate.weak_pd   = 1'b1;
            next_timer.fast_dis = 1'b1;
         end
         st_inrush, st_normal: begin
            next_gate.pump_en     = 1'b1;
            next_timer.flt_charge = limiting;
            next_timer.slow_dis   = !limiting;
         end
         st_fault: begin
            next_gate.strong_pd = 1'b1;
         end
         st_latched, st_rst_down, st_rst_last: begin
            next_gate.weak_pd   = 1'b1;
            next_timer.slow_dis = 1'b1;
         end
         st_rst_up: begin
            next_gate.weak_pd     = 1'b1;
            next_timer.flt_charge = 1'b1;
         end
         default: begin
            next_gate.strong_pd = 1'b1;
            next_timer.ground   = 1'b1;
         end
      endcase
      // breaker trips the gate at once; it releases when current drops
      if (s.breaker && (state == st_inrush || state == st_normal)) begin
         next_gate.pump_en   = 1'b0;
         next_gate.strong_pd = 1'b1;
      end
      if (supply_bad && (state == st_inrush || state == st_normal)) begin
         next_gate.pump_en = 1'b0;
         next_gate.weak_pd = 1'b1;
      end
   end

   // registered gate drive; reset leaves the strong pull-down on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gate_ctl <= '{strong_pd: 1'b1, weak_pd: 1'b0, pump_en: 1'b0};
      end else begin
         gate_ctl <= next_gate;
      end
   end

   // registered timer drive; reset keeps the timer node grounded
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         timer_ctl <= '{ground: 1'b1, default: 1'b0};
      end else begin
         timer_ctl <= next_timer;
      end
   end

   // power good follows the synced feedback comparator, never ahead of power-on
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         power_good_out <= 1'b0;
      end else begin
         power_good_out <= s.fb_hi && s.por_ok;
      end
   end

endmodule

// File: src/hotswap_pkg.sv
package hotswap_pkg;

   // apb register map (byte addresses, one aligned word each)
   localparam logic [7:0] ctrl_addr    = 8'h00;
   localparam logic [7:0] status_addr  = 8'h04;
   localparam logic [7:0] warn_addr    = 8'h08;

   // control register fields
   localparam int ctrl_clear_bit    = 0;   // write 1: clear faults (pulse)
   localparam int ctrl_retry_lsb    = 4;   // retry count select, 3 bits
   localparam int ctrl_wmask_lsb    = 8;   // warning mask, 5 bits

   // retry count encodings
   localparam logic [2:0] retry_zero     = 3'h0;
   localparam logic [2:0] retry_one      = 3'h1;
   localparam logic [2:0] retry_two      = 3'h2;
   localparam logic [2:0] retry_four     = 3'h3;
   localparam logic [2:0] retry_eight    = 3'h4;
   localparam logic [2:0] retry_sixteen  = 3'h5;
   localparam logic [2:0] retry_infinite = 3'h6;
   localparam logic [2:0] retry_pin      = 3'h7;

   // reset values
   localparam logic [2:0] retry_reset   = retry_pin;
   localparam logic [4:0] wmask_reset   = 5'h1F;

   // timer cycles in the automatic restart sequence
   localparam logic [3:0] restart_cycles = 4'h7;

   // sequencer states
   typedef enum logic [3:0] {
      st_por      = 4'b0000,
      st_insert   = 4'b0001,
      st_ins_dis  = 4'b0010,
      st_wait_uv  = 4'b0011,
      st_inrush   = 4'b0100,
      st_normal   = 4'b0101,
      st_fault    = 4'b0110,
      st_latched  = 4'b0111,
      st_rst_up   = 4'b1000,
      st_rst_down = 4'b1001,
      st_rst_last = 4'b1010
   } seq_state_t;

   // comparator results from the analog side
   typedef struct packed {
      logic por_ok;        // supply above power-on threshold
      logic uv_ok;         // system supply above undervoltage level
      logic ov_hi;         // system supply above overvoltage level
      logic timer_hi;      // timer at upper level
      logic timer_lo;      // timer below restart level
      logic timer_mid;     // timer below middle (lower cycle) level
      logic cur_lim;       // current limit active
      logic pwr_lim;       // power limit active
      logic breaker;       // severe over-current
      logic fb_hi;         // feedback above rising threshold
   } sense_t;

   // timer node control
   typedef struct packed {
      logic ground;        // hold timer node at ground
      logic ins_charge;    // slow insertion charge
      logic flt_charge;    // fault timer charge
      logic fast_dis;      // fast discharge
      logic slow_dis;      // slow discharge
   } timer_ctl_t;

   // gate drive control
   typedef struct packed {
      logic strong_pd;     // strong pull-down
      logic weak_pd;       // weak pull-down
      logic pump_en;       // charge pump on
   } gate_ctl_t;

endpackage

// File: verification/hotswap_plant.sv
`timescale 1ns/1ps
// behavioural pass switch, timer capacitor and supply sensing
module hotswap_plant
   import hotswap_pkg::*;
#(
   parameter int hi_lvl  = 40,
   parameter int mid_lvl = 24,
   parameter int lo_lvl  = 6
)(
   input  wire logic                    pclk,      // clock
   input  wire hotswap_pkg::gate_ctl_t  gate_ctl,  // gate selects
   input  wire hotswap_pkg::timer_ctl_t timer_ctl, // timer selects
   input  wire logic                    por,       // supply above power-on level
   input  wire logic                    uv,        // supply above undervoltage level
   input  wire logic                    ov,        // supply above overvoltage level
   input  wire logic [1:0]              lim,       // load wants power, current limit
   input  wire logic                    brk,       // hard short on the output
   output hotswap_pkg::sense_t          sense      // comparator results
);
   int lvl  = 0;
   int vout = 0;
   // timer node: any discharge beats charging, ground beats all
   always @(posedge pclk) begin
      if (timer_ctl.ground) lvl <= 0;
      else if (timer_ctl.fast_dis) lvl <= (lvl > 4) ? lvl - 4 : 0;
      else if (timer_ctl.slow_dis) lvl <= (lvl > 0) ? lvl - 1 : 0;
      else if ((timer_ctl.ins_charge || timer_ctl.flt_charge) && lvl < 50) lvl <= lvl + 1;
   end
   // output collapses at once when the gate is off, so limiting restarts in inrush
   always @(posedge pclk) begin
      if (!gate_ctl.pump_en) vout <= 0;
      else if (lim == 2'b00 && vout < 30) vout <= vout + 1;
   end
   // limits only show while the gate conducts
   assign sense = '{por_ok: por, uv_ok: uv, ov_hi: ov, timer_hi: lvl >= hi_lvl,
                    timer_lo: lvl < lo_lvl, timer_mid: lvl < mid_lvl,
                    cur_lim: lim[0] && gate_ctl.pump_en, pwr_lim: lim[1] && gate_ctl.pump_en,
                    breaker: brk, fb_hi: vout >= 20};
endmodule

// File: verification/hotswap_gate_sequencer_props.sv
`timescale 1ns/1ps
// port checks; comparator inputs pass two sync stages first
module hotswap_gate_sequencer_props
   import hotswap_pkg::*;
(
   input wire logic                    pclk,           // clock
   input wire logic                    presetn,        // reset, active low
   input wire hotswap_pkg::sense_t     sense,          // comparator results
   input wire hotswap_pkg::gate_ctl_t  gate_ctl,       // gate selects
   input wire hotswap_pkg::timer_ctl_t timer_ctl,      // timer selects
   input wire logic                    power_good_out, // power good
   input wire logic                    smb_alert_n     // alert, active low
);
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_por_hold;
      (!sense.por_ok)[*5] |-> gate_ctl.strong_pd && timer_ctl.ground;
   endproperty
   a_por_hold: assert property (p_por_hold) else $error("switch not held below power-on");
   property p_insert;
      timer_ctl.ins_charge |-> gate_ctl.weak_pd && !gate_ctl.pump_en;
   endproperty
   a_insert: assert property (p_insert) else $error("gate not held during insertion");
   property p_gate_on;
      timer_ctl.fast_dis && sense.timer_lo && sense.uv_ok && !sense.ov_hi |-> ##[1:6] gate_ctl.pump_en;
   endproperty
   a_gate_on: assert property (p_gate_on) else $error("gate late after insertion");
   property p_flt_chg;
      (gate_ctl.pump_en && !power_good_out && (sense.cur_lim || sense.pwr_lim))[*5]
         |-> timer_ctl.flt_charge || gate_ctl.strong_pd;
   endproperty
   a_flt_chg: assert property (p_flt_chg) else $error("fault timer idle while limiting");
   property p_pgood;
      $rose(power_good_out) |-> $past(sense.fb_hi, 3);
   endproperty
   a_pgood: assert property (p_pgood) else $error("power good without feedback");
   property p_fault;
      gate_ctl.pump_en && timer_ctl.flt_charge && sense.timer_hi && (sense.cur_lim || sense.pwr_lim)
         |-> ##[1:6] gate_ctl.strong_pd;
   endproperty
   a_fault: assert property (p_fault) else $error("no shutdown at fault timeout");
   property p_hold;
      $rose(gate_ctl.strong_pd) |-> (!gate_ctl.pump_en)[*8];
   endproperty
   a_hold: assert property (p_hold) else $error("gate back on right after shutdown");
   property p_supply;
      (sense.ov_hi || !sense.uv_ok)[*5] |-> !gate_ctl.pump_en;
   endproperty
   a_supply: assert property (p_supply) else $error("gate on with supply out of range");
   property p_brk;
      sense.breaker[*5] |-> gate_ctl.strong_pd && !gate_ctl.pump_en;
   endproperty
   a_brk: assert property (p_brk) else $error("breaker did not pull gate");
   property p_alert;
      $rose(sense.por_ok) |-> ##4 !smb_alert_n;
   endproperty
   a_alert: assert property (p_alert) else $error("no alert after power-on");
   property p_sync;
      $rose(timer_ctl.ins_charge) |-> $past(sense.por_ok, 4);
   endproperty
   a_sync: assert property (p_sync) else $error("insertion began before sync");
   c_pg: cover property (gate_ctl.pump_en && power_good_out);
   c_fault: cover property (gate_ctl.pump_en ##1 gate_ctl.strong_pd);
   c_slow: cover property (timer_ctl.flt_charge ##1 timer_ctl.slow_dis);
endmodule
bind hotswap_gate_sequencer hotswap_gate_sequencer_props i_props (.pclk(pclk), .presetn(presetn),
   .sense(sense), .gate_ctl(gate_ctl), .timer_ctl(timer_ctl),
   .power_good_out(power_good_out), .smb_alert_n(smb_alert_n));

// File: verification/hotswap_gate_sequencer_tb.sv
`timescale 1ns/1ps
// sequencer bench: apb tasks, plant model on the analog side
module hotswap_gate_sequencer_tb;
   import hotswap_pkg::*;
   localparam int b_slow = 0, b_fast = 1, b_fchg = 2, b_ichg = 3, b_pump = 5;
   localparam int b_weak = 6, b_strong = 7, b_pg = 8, b_tlo = 9;
   logic        pclk, presetn, psel, penable, pwrite, retry_latch_sel, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, q;
   logic        pready, pslverr, power_good_out, smb_alert_n, por, uv, ov, brk, hi_q;
   logic [4:0]  warn_cross;
   logic [1:0]  lim;
   sense_t      sense;
   gate_ctl_t   gate_ctl;
   timer_ctl_t  timer_ctl;
   int          n_fail = 0, check_count = 0, hi_n = 0, i;
   wire logic [9:0] obs = {sense.timer_lo, power_good_out, gate_ctl, timer_ctl};
   hotswap_gate_sequencer i_hotswap_gate_sequencer (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .sense(sense), .retry_latch_sel(retry_latch_sel),
      .warn_cross(warn_cross), .gate_ctl(gate_ctl), .timer_ctl(timer_ctl),
      .power_good_out(power_good_out), .smb_alert_n(smb_alert_n));
   hotswap_plant i_hotswap_plant (.pclk(pclk), .gate_ctl(gate_ctl), .timer_ctl(timer_ctl),
      .por(por), .uv(uv), .ov(ov), .lim(lim), .brk(brk), .sense(sense));
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end
   // run needs under 2000 cycles; far beyond that is a hang
   initial begin
      repeat (20000) @(posedge pclk);
      n_fail++;
      report_and_stop();
   end
   // counts timer upper-level crossings during the restart sequence
   always @(posedge pclk) begin
      hi_q <= sense.timer_hi;
      if (sense.timer_hi && !hi_q) hi_n++;
   end
   task automatic chk(input logic [31:0] e, input logic [31:0] s, input string n);
      check_count++;
      if (s !== e) begin
         n_fail++;
         $display("wrong value %s expected %h seen %h", n, e, s);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge pclk);
   endtask
   // one apb transfer; request held until pready is sampled high
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      q = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // bounded wait on one output, then compare it
   task automatic wt(input int b, input logic v, input int n);
      for (i = 0; i < n && obs[b] !== v; i++) @(posedge pclk);
      chk({31'h0, v}, {31'h0, obs[b]}, $sformatf("output bit %0d", b));
   endtask
   // latched restart needs a supply dip while the timer is low
   task automatic dip;
      uv <= 1'b0;
      wt(b_tlo, 1'b1, 300);
      cyc(8);
      uv <= 1'b1;
      wt(b_pump, 1'b1, 300);
   endtask
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      {psel, penable, pwrite, paddr, pwdata, por, uv, ov, brk, lim, warn_cross} = '0;
      retry_latch_sel = 1'b1;
      presetn = 1'b0;
      repeat (4) @(posedge pclk);
      chk(32'h90, {24'h0, obs[7:0]}, "reset outputs");
      presetn <= 1'b1;
      cyc(6);
      chk(32'h90, {24'h0, obs[7:0]}, "pre-power-on outputs");
      apb(1'b0, ctrl_addr, 32'h0);
      chk(32'h00001F70, q, "control reset");
      apb(1'b0, 8'h0C, 32'h0);
      chk(32'h1, {31'h0, err}, "unmapped error");
      chk(32'h0, q, "unmapped data");
      por <= 1'b1;
      wt(b_ichg, 1'b1, 20);
      chk(32'h2, {29'h0, gate_ctl}, "insertion gate");
      chk(32'h0, {31'h0, smb_alert_n}, "defaults alert");
      wt(b_fast, 1'b1, 100);
      cyc(40);
      chk(32'h0, {31'h0, gate_ctl.pump_en}, "gate in undervoltage");
      uv <= 1'b1;
      wt(b_pump, 1'b1, 20);
      lim <= 2'b01;
      wt(b_fchg, 1'b1, 20);
      cyc(5);
      lim <= 2'b00;
      wt(b_slow, 1'b1, 20);
      wt(b_pg, 1'b1, 100);
      ov <= 1'b1;
      wt(b_pump, 1'b0, 20);
      chk(32'h2, {29'h0, gate_ctl}, "overvoltage gate");
      ov <= 1'b0;
      wt(b_pump, 1'b1, 100);
      lim <= 2'b10;
      wt(b_strong, 1'b1, 200);
      lim <= 2'b00;
      wt(b_weak, 1'b1, 20);
      uv <= 1'b0;
      cyc(8);
      uv <= 1'b1;
      cyc(80);
      chk(32'h0, {31'h0, gate_ctl.pump_en}, "restart with timer high");
      dip();
      retry_latch_sel <= 1'b0;
      lim <= 2'b01;
      wt(b_strong, 1'b1, 200);
      lim <= 2'b00;
      hi_n = 0;
      wt(b_pump, 1'b1, 2000);
      chk(32'h7, hi_n, "restart timer cycles");
      apb(1'b1, ctrl_addr, 32'h00001F00);
      lim <= 2'b01;
      wt(b_strong, 1'b1, 200);
      lim <= 2'b00;
      cyc(400);
      chk(32'h0, {31'h0, gate_ctl.pump_en}, "zero retries");
      dip();
      // every retry code reads back, ending on the pin setting
      for (int c = 0; c < 8; c++) begin
         apb(1'b1, ctrl_addr, 32'h1F00 | (c << 4));
         apb(1'b0, ctrl_addr, 32'h0);
         chk(32'h1F00 | (c << 4), q, "retry select");
      end
      apb(1'b0, status_addr, 32'h0);
      chk(32'h1, {31'h0, q[4]}, "defaults flag");
      apb(1'b1, ctrl_addr, 32'h00001F71);
      apb(1'b0, status_addr, 32'h0);
      chk(32'h0, {31'h0, q[4]}, "defaults flag cleared");
      warn_cross <= 5'h04;
      cyc(1);
      warn_cross <= 5'h00;
      cyc(4);
      chk(32'h0, {31'h0, smb_alert_n}, "enabled warning");
      apb(1'b0, warn_addr, 32'h0);
      chk(32'h4, q, "sticky warning");
      apb(1'b1, ctrl_addr, 32'h00000070);
      cyc(4);
      chk(32'h1, {31'h0, smb_alert_n}, "masked warning");
      apb(1'b1, ctrl_addr, 32'h00001F71);
      cyc(4);
      chk(32'h1, {31'h0, smb_alert_n}, "alert after clear");
      brk <= 1'b1;
      wt(b_strong, 1'b1, 8);
      cyc(20);
      brk <= 1'b0;
      presetn <= 1'b0;
      por <= 1'b0;
      cyc(2);
      chk(32'h90, {24'h0, obs[7:0]}, "second reset");
      presetn <= 1'b1;
      cyc(3);
      por <= 1'b1;
      wt(b_fast, 1'b1, 100);
      wt(b_pump, 1'b1, 100);
      report_and_stop();
   end
endmodule
